// ---- hdl/ppmc_defs.svh ----
// Offsets, field positions, reset values and timing counts of the capability word.
`ifndef PPMC_DEFS_SVH
`define PPMC_DEFS_SVH

`define PPMC_CAP_OFFSET       8'h40
`define PPMC_CAP_RESET        32'hff820001
`define PPMC_CAP_LIST_EN_BIT  4
`define PPMC_WAKE_MSB         31
`define PPMC_WAKE_LSB         27
`define PPMC_WAKE_D3COLD_BIT  4
`define PPMC_D2_SUP_BIT       26
`define PPMC_D1_SUP_BIT       25
`define PPMC_AUX_MSB          24
`define PPMC_AUX_LSB          22
`define PPMC_DSI_BIT          21
`define PPMC_RSVD_BIT         20
`define PPMC_WAKE_CLK_BIT     19
`define PPMC_VER_MSB          18
`define PPMC_VER_LSB          16
`define PPMC_NEXT_MSB         15
`define PPMC_NEXT_LSB         8
`define PPMC_ID_MSB           7
`define PPMC_ID_LSB           0
`define PPMC_WAKE_RESET       5'h1f
`define PPMC_DSI_RESET        1'h0
`define PPMC_AUX_320MA        3'h6
`define PPMC_AUX_SELF         3'h0
`define PPMC_WAKE_CLK_NEEDED  1'h0
`define PPMC_VERSION          3'h2
`define PPMC_NEXT_PTR         8'h00
`define PPMC_CAP_ID           8'h01
`define PPMC_D3COLD_INDEX     3'h4
`define PPMC_READ_LATENCY     1

`endif

// ---- hdl/ppmc_pkg.sv ----
// Types shared by the power-management capability block.
package ppmc_pkg;

    typedef enum logic [1:0] {
        PPMC_IDLE   = 2'b01,
        PPMC_ANSWER = 2'b10
    } ppmc_rd_state_t;

    typedef logic [1:0] ppmc_pstate_t;
    typedef logic [4:0] ppmc_wake_mask_t;
    typedef logic [31:0] ppmc_word_t;

endpackage

// ---- hdl/ppmc_wake_if.sv ----
// Signals between the capability register and the wake output stage.
interface ppmc_wake_if;
    import ppmc_pkg::*;

    ppmc_wake_mask_t wake_state_support;
    logic [2:0]      state_index;
    logic            wake_pending;
    logic            wake_output_enable;
    logic            wake_event_out;

    modport cap (
        output wake_state_support,
        output state_index,
        output wake_pending,
        output wake_output_enable,
        input  wake_event_out
    );

    modport wake (
        input  wake_state_support,
        input  state_index,
        input  wake_pending,
        input  wake_output_enable,
        output wake_event_out
    );
endinterface

// ---- hdl/ppmc_wake.sv ----
// Wake output stage gated by the enable bit and the reported state support.
module ppmc_wake
    import ppmc_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  rst,
    ppmc_wake_if.wake  wk
);
    logic wake_q;
    logic next_wake_q;

    always_comb begin
        next_wake_q = wk.wake_output_enable & wk.wake_pending
                      & wk.wake_state_support[wk.state_index];
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= next_wake_q;
        end
    end

    assign wk.wake_event_out = wake_q;
endmodule

// ---- hdl/ppmc_cap.sv ----
// Read-only power-management capability word with its configuration read port.
`include "ppmc_defs.svh"

module ppmc_cap
    import ppmc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       cfg_rd,
    input  wire logic       cfg_wr,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic [31:0] config_command_status,
    output logic            cfg_claim,
    output logic            cfg_rdata_valid,
    output logic [31:0]     cfg_rdata,
    input  wire logic       aux_supply_detect,
    input  wire logic       in_d3cold,
    input  wire logic [1:0] power_state,
    input  wire logic       ee_load,
    input  wire logic [4:0] ee_wake_state_support,
    input  wire logic       ee_dsi,
    input  wire logic       wake_pending,
    input  wire logic       wake_output_enable,
    output logic            wake_event_out
);
    // Fields that the EEPROM may load; every other field but the aux current, which follows the reported D3cold wake bit, is constant.
    ppmc_wake_mask_t wake_state_support;
    ppmc_wake_mask_t next_wake_state_support;
    logic            dsi;
    logic            next_dsi;
    ppmc_rd_state_t  rd_state;
    ppmc_rd_state_t  next_rd_state;
    ppmc_word_t      rdata_q;
    ppmc_word_t      next_rdata_q;
    logic            hit;
    logic            rd_take;
    logic            unused_wdata;
    // Word as reported now, with the D3cold wake bit qualified by aux power.
    ppmc_wake_mask_t reported_mask;
    ppmc_word_t      live_word;

    ppmc_wake_if wk ();

    // Reported wake mask with the D3cold bit qualified by auxiliary power.
    function automatic ppmc_wake_mask_t reported_wake(input ppmc_wake_mask_t raw,
                                                      input logic aux);
        ppmc_wake_mask_t m;
        m = raw;
        m[`PPMC_WAKE_D3COLD_BIT] = raw[`PPMC_WAKE_D3COLD_BIT] & aux;
        return m;
    endfunction

    // Offset match qualified by the capability-list enable bit.
    function automatic logic cap_selected(input logic [7:0]  addr,
                                          input logic [31:0] ccs);
        logic sel;
        sel = (addr == `PPMC_CAP_OFFSET) & ccs[`PPMC_CAP_LIST_EN_BIT];
        return sel;
    endfunction

    // Auxiliary-current code for the reported D3cold wake support.
    function automatic logic [2:0] aux_current(input logic d3cold_wake);
        logic [2:0] code;
        // 110 is 320 mA, 000 self powered.
        if (d3cold_wake) begin
            code = `PPMC_AUX_320MA;
        end else begin
            code = `PPMC_AUX_SELF;
        end
        return code;
    endfunction

    // Slot of the wake mask that applies now: the power state, or D3cold when power is off.
    function automatic logic [2:0] state_index_of(input logic         d3cold,
                                                  input ppmc_pstate_t ps);
        logic [2:0] idx;
        if (d3cold) begin
            idx = `PPMC_D3COLD_INDEX;
        end else begin
            idx = {1'b0, ps};
        end
        return idx;
    endfunction

    // Assembles the capability word from its fields.
    function automatic ppmc_word_t cap_word(input ppmc_wake_mask_t wake,
                                            input logic            dsi_bit);
        ppmc_word_t w;
        w = 32'h0000_0000;
        w[`PPMC_WAKE_MSB:`PPMC_WAKE_LSB] = wake;
        w[`PPMC_D2_SUP_BIT] = 1'b1;
        w[`PPMC_D1_SUP_BIT] = 1'b1;
        w[`PPMC_AUX_MSB:`PPMC_AUX_LSB] = aux_current(wake[`PPMC_WAKE_D3COLD_BIT]);
        w[`PPMC_DSI_BIT] = dsi_bit;
        w[`PPMC_RSVD_BIT] = 1'b0;
        w[`PPMC_WAKE_CLK_BIT] = `PPMC_WAKE_CLK_NEEDED;
        w[`PPMC_VER_MSB:`PPMC_VER_LSB] = `PPMC_VERSION;
        w[`PPMC_NEXT_MSB:`PPMC_NEXT_LSB] = `PPMC_NEXT_PTR;
        w[`PPMC_ID_MSB:`PPMC_ID_LSB] = `PPMC_CAP_ID;
        return w;
    endfunction

    assign hit     = cap_selected(cfg_addr, config_command_status);
    // Only a read that hits starts an answer; writes end at the claim.
    assign rd_take = cfg_rd & hit;

    // Writes are claimed so the host completes them, and their data is dropped.
    assign cfg_claim    = (cfg_rd | cfg_wr) & hit;
    assign unused_wdata = ^cfg_wdata;

    // One reported mask feeds both the read word and the wake gate, so they agree.
    assign reported_mask = reported_wake(wake_state_support, aux_supply_detect);
    assign live_word     = cap_word(reported_mask, dsi);

    always_comb begin
        next_wake_state_support = wake_state_support;
        next_dsi                = dsi;
        if (ee_load) begin
            // A load outside D3cold still takes the initialization flag but keeps the mask.
            // EEPROM value taken in D3cold.
            if (in_d3cold) begin
                next_wake_state_support = ee_wake_state_support;
            end
            next_dsi = ee_dsi;
        end
        // no write path to the fields.
    end

    // hard reset value, soft reset not seen here.
    // Only the hard reset restores the word; there is no soft reset input to disturb it.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_state_support <= `PPMC_WAKE_RESET;
            dsi                <= `PPMC_DSI_RESET;
        end else begin
            wake_state_support <= next_wake_state_support;
            dsi                <= next_dsi;
        end
    end

    // Read answer machine: a taken read is answered by a registered word one cycle later.
    always_comb begin
        next_rd_state = rd_state;
        next_rdata_q  = rdata_q;
        case (rd_state)
            PPMC_IDLE: begin
                if (rd_take) begin
                    next_rd_state = PPMC_ANSWER;
                    next_rdata_q  = live_word;
                end
            end
            PPMC_ANSWER: begin
                // A read arriving in the answer cycle is claimed but not answered.
                next_rd_state = PPMC_IDLE;
                next_rdata_q  = 32'h0000_0000;
            end
            default: begin
                // An unknown state code falls back to idle with an empty data bus.
                next_rd_state = PPMC_IDLE;
                next_rdata_q  = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_state <= PPMC_IDLE;
            rdata_q  <= 32'h0000_0000;
        end else begin
            rd_state <= next_rd_state;
            rdata_q  <= next_rdata_q;
        end
    end

    // The data bus reads zero outside the answer cycle.
    assign cfg_rdata_valid = (rd_state == PPMC_ANSWER);
    assign cfg_rdata       = rdata_q;

    // Signals handed to the wake output stage.
    assign wk.state_index        = state_index_of(in_d3cold, power_state);
    assign wk.wake_state_support = reported_mask;
    assign wk.wake_pending       = wake_pending;
    assign wk.wake_output_enable = wake_output_enable;
    assign wake_event_out        = wk.wake_event_out;

    // The wake output is registered, so it trails a change of the enable by one cycle.
    ppmc_wake ppmc_wake_i (
        .mclk (mclk),
        .rst  (rst),
        .wk   (wk.wake)
    );
endmodule

// ---- dv/ppmc_cap_sva.sv ----
// Concurrent checks on the capability word read port and the wake output.
module ppmc_cap_sva (
    input logic        mclk,
    input logic        rst,
    input logic [7:0]  cfg_addr,
    input logic        cfg_rd,
    input logic        cfg_wr,
    input logic [31:0] config_command_status,
    input logic        cfg_claim,
    input logic        cfg_rdata_valid,
    input logic [31:0] cfg_rdata,
    input logic        aux_supply_detect,
    input logic        wake_pending,
    input logic        wake_output_enable,
    input logic        wake_event_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_claim_decode:
    assert property (cfg_claim == ((cfg_rd | cfg_wr) && cfg_addr == 8'h40
        && config_command_status[4])) else $error("claim decode wrong");
    a_read_answer:
    assert property (cfg_rd && cfg_claim && !cfg_rdata_valid |=> cfg_rdata_valid
        && cfg_rdata[7:0] == 8'h01) else $error("read not answered");
    a_valid_cause:
    assert property (cfg_rdata_valid |-> $past(cfg_rd && cfg_claim)) else $error("stray valid");
    a_refused_read:
    assert property (cfg_rd && !cfg_claim |=> !cfg_rdata_valid) else $error("refused read answered");
    a_fixed_fields:
    assert property (cfg_rdata_valid |-> cfg_rdata[26:25] == 2'b11
        && cfg_rdata[20:0] == 21'h020001) else $error("fixed field wrong");
    a_aux_gate:
    assert property (cfg_rdata_valid && !$past(aux_supply_detect) |-> !cfg_rdata[31])
        else $error("d3cold wake without aux");
    a_aux_current:
    assert property (cfg_rdata_valid |-> cfg_rdata[24:22] == (cfg_rdata[31] ? 3'h6 : 3'h0))
        else $error("aux current wrong");
    a_wake_gate:
    assert property (wake_event_out |-> $past(wake_output_enable && wake_pending))
        else $error("wake without enable");
endmodule

bind ppmc_cap ppmc_cap_sva ppmc_cap_sva_i (.mclk, .rst, .cfg_addr, .cfg_rd, .cfg_wr,
    .config_command_status, .cfg_claim, .cfg_rdata_valid, .cfg_rdata, .aux_supply_detect,
    .wake_pending, .wake_output_enable, .wake_event_out);

// ---- dv/ppmc_host.sv ----
// Host bridge model issuing configuration reads and writes.
module ppmc_host (
    input  wire logic        mclk,
    input  wire logic        cfg_rdata_valid,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [7:0]       cfg_addr,
    output logic [31:0]      cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'hbf;
        cfg_wdata = 32'h0;
    end
    // One request, answer taken one cycle later, then two idle cycles before the next call drives its request.
    task automatic acc(input logic w, input logic [7:0] a, output logic v, output logic [31:0] d);
        @(posedge mclk);
        #1;
        cfg_addr = a;
        cfg_wr = w;
        cfg_rd = !w;
        cfg_wdata = {32{w}};
        @(posedge mclk);
        #1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = ~a;
        cfg_wdata = 32'h0;
        v = cfg_rdata_valid;
        d = cfg_rdata;
        @(posedge mclk);
        #1;
    endtask
endmodule

// ---- dv/ppmc_cap_bench.sv ----
// Self-checking bench of the capability word.
module ppmc_cap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic aux; logic en; logic [7:0] a; logic v;
                           logic [31:0] w;} ppmc_row_t;
    logic        mclk, rst, cfg_rd, cfg_wr, claim, valid, aux, d3c, eel, eedsi, pend, wen, wout, v;
    logic [7:0]  addr;
    logic [31:0] wdata, ccs, rdata, got;
    logic [4:0]  eew;
    logic [1:0]  ps;
    int          num_errors = 0;
    int          num_checks = 0;
    ppmc_row_t   rows[4] = '{'{1, 1, 8'h40, 1, 32'hff820001}, '{0, 1, 8'h40, 1, 32'h7e020001},
                             '{1, 0, 8'h40, 0, 32'h0}, '{1, 1, 8'h44, 0, 32'h0}};

    ppmc_cap ppmc_cap_i (.mclk(mclk), .rst(rst), .cfg_addr(addr), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_wdata(wdata), .config_command_status(ccs), .cfg_claim(claim),
        .cfg_rdata_valid(valid), .cfg_rdata(rdata), .aux_supply_detect(aux), .in_d3cold(d3c),
        .power_state(ps), .ee_load(eel), .ee_wake_state_support(eew), .ee_dsi(eedsi),
        .wake_pending(pend), .wake_output_enable(wen), .wake_event_out(wout));
    ppmc_host ppmc_host_i (.mclk(mclk), .cfg_rdata_valid(valid), .cfg_rdata(rdata),
        .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(addr), .cfg_wdata(wdata));

    function automatic logic [31:0] word(logic [4:0] m, logic dsi, logic ax);
        return {m[4] & ax, m[3:0], 2'b11, ((m[4] & ax) ? 3'h6 : 3'h0), dsi, 21'h020001};
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic eeload(logic d3, logic [4:0] m, logic dsi);
        d3c = d3;
        eew = m;
        eedsi = dsi;
        eel = 1'b1;
        @(posedge mclk);
        #1;
        eel = 1'b0;
        ppmc_host_i.acc(1'b0, 8'h40, v, got);
    endtask

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #20000;
        num_errors++;
        results();
    end
    initial begin
        {rst, aux, ccs} = {2'b11, 32'h10};
        {d3c, eel, eew, eedsi, pend, wen, ps} = '0;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        foreach (rows[i]) begin
            aux = rows[i].aux;
            ccs = {27'h0, rows[i].en, 4'h0};
            ppmc_host_i.acc(1'b0, rows[i].a, v, got);
            chk("valid", {31'h0, rows[i].v}, {31'h0, v});
            chk("word", rows[i].w, got);
        end
        ppmc_host_i.acc(1'b1, 8'h40, v, got);
        ppmc_host_i.acc(1'b0, 8'h40, v, got);
        chk("after write", 32'hff820001, got);
        eeload(1'b1, 5'h0a, 1'b1);
        chk("load d3cold", word(5'h0a, 1'b1, 1'b1), got);
        eeload(1'b0, 5'h1f, 1'b0);
        chk("load d0", word(5'h0a, 1'b0, 1'b1), got);
        pend = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wen = i[2];
            ps = i[1:0];
            repeat (2) @(posedge mclk);
            #1;
            chk("wake", {27'h0, i[2] & (5'h0a >> i[1:0]) & 5'h01}, {31'h0, wout});
        end
        d3c = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("wake d3cold", 32'h0, {31'h0, wout});
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        rst = 1'b0;
        ppmc_host_i.acc(1'b0, 8'h40, v, got);
        chk("rereset", 32'hff820001, got);
        chk("wake d3cold aux", 32'h1, {31'h0, wout});
        aux = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk("wake no aux", 32'h0, {31'h0, wout});
        results();
    end
endmodule
